/* File: hsp_pkg.sv */
package hsp_pkg;

    // ****************************************
    // reset values and fixed address bit
    // ****************************************
    localparam logic STRAP_BUS_ROLE_RST = 1'h1;
    localparam logic STRAP_POL_RST = 1'h0;
    localparam logic STRAP_GANG_RST = 1'h1;
    localparam logic STRAP_PWR_DIS_RST = 1'h0;
    localparam logic STRAP_TEST_RST = 1'h0;
    localparam logic SLAVE_ADDR_BIT3 = 1'h1;
    localparam logic [3:0] STATUS_RST = 4'h0;
    localparam logic [1:0] POWER_REQ_RST = 2'h0;
    localparam logic [1:0] PORT_OC_RST = 2'h0;
    localparam logic HUB_OC_RST = 1'h0;
    localparam logic [2:0] SLAVE_ADDR_RST = 3'h0;
    localparam int SLAVE_ADDR_W = 3;
    localparam int CAPTURE_DELAY = 1;

    // ****************************************
    // sequencing states
    // ****************************************
    typedef enum logic [1:0] {
        HSP_SAMPLE = 2'h1,
        HSP_RUN = 2'h2
    } hsp_state_t;

endpackage : hsp_pkg

/* File: hsp_strap_if.sv */
`timescale 1ns/100ps
interface hsp_strap_if;
    logic bus_role;
    logic pol;
    logic gang;
    logic pwr_dis;
    logic test;
    logic run;

    modport latch (output bus_role, pol, gang, pwr_dis, test, run);
    modport user (input bus_role, pol, gang, pwr_dis, test, run);
endinterface : hsp_strap_if

/* File: hsp_strap_latch.sv */
`timescale 1ns/100ps
module hsp_strap_latch (
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    // strap pin levels
    input wire logic bus_role_strap_i,
    input wire logic power_ctl_polarity_strap_i,
    input wire logic gang_strap_i,
    input wire logic power_switching_disable_strap_i,
    input wire logic test_i,
    // captured values
    hsp_strap_if.latch st
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        hsp_pkg::hsp_state_t state;
        logic bus_role;
        logic pol;
        logic gang;
        logic pwr_dis;
        logic test;
    } hsp_latch_t;

    hsp_latch_t s_q;
    hsp_latch_t s_d;

    always_comb
    begin
        s_d = s_q;
        unique case (s_q.state)
            hsp_pkg::HSP_SAMPLE:
            begin
                // first clock-enabled edge after release takes the pins
                s_d.bus_role = bus_role_strap_i;
                s_d.pol = power_ctl_polarity_strap_i;
                s_d.gang = gang_strap_i;
                s_d.pwr_dis = power_switching_disable_strap_i;
                s_d.test = test_i;
                s_d.state = hsp_pkg::HSP_RUN;
            end
            hsp_pkg::HSP_RUN:
            begin
                s_d.state = hsp_pkg::HSP_RUN;
            end
            default:
            begin
                s_d.state = hsp_pkg::HSP_SAMPLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            s_q.state <= hsp_pkg::HSP_SAMPLE;
            s_q.bus_role <= hsp_pkg::STRAP_BUS_ROLE_RST;
            s_q.pol <= hsp_pkg::STRAP_POL_RST;
            s_q.gang <= hsp_pkg::STRAP_GANG_RST;
            s_q.pwr_dis <= hsp_pkg::STRAP_PWR_DIS_RST;
            s_q.test <= hsp_pkg::STRAP_TEST_RST;
        end
        else if (ce_i)
        begin
            s_q <= s_d;
        end
    end

    assign st.bus_role = s_q.bus_role;
    assign st.pol = s_q.pol;
    assign st.gang = s_q.gang;
    assign st.pwr_dis = s_q.pwr_dis;
    assign st.test = s_q.test;
    assign st.run = (s_q.state == hsp_pkg::HSP_RUN);

endmodule : hsp_strap_latch

/* File: hsp_strap_top.sv */
`timescale 1ns/100ps
module hsp_strap_top (
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    // shared strap/status pins, plus test input
    input wire logic bus_role_strap_i,
    output logic dn2_superspeed_status_o,
    output logic dn2_superspeed_status_oe_o,
    input wire logic power_ctl_polarity_strap_i,
    output logic dn1_superspeed_status_o,
    output logic dn1_superspeed_status_oe_o,
    input wire logic slave_addr_bit2_strap_i,
    output logic upstream_highspeed_status_o,
    output logic upstream_highspeed_status_oe_o,
    input wire logic power_switching_disable_strap_i,
    output logic upstream_superspeed_status_o,
    output logic upstream_superspeed_status_oe_o,
    input wire logic test_i,
    // hub core link status
    input wire logic dn1_ss_conn_i,
    input wire logic dn2_ss_conn_i,
    input wire logic up_hs_conn_i,
    input wire logic up_ss_conn_i,
    // port power requests and overcurrent
    input wire logic [1:0] port_power_req_i,
    input wire logic port1_overcurrent_n_i,
    input wire logic port2_overcurrent_n_i,
    output logic [1:0] port_power_control_o,
    output logic [1:0] port_overcurrent_o,
    output logic hub_overcurrent_o,
    // serial engine steering
    output logic eeprom_master_sel_o,
    output logic smbus_slave_sel_o,
    output logic [2:0] smbus_slave_addr_o,
    // configuration status
    output logic gang_mode_o,
    output logic power_switching_en_o,
    output logic factory_test_o,
    output logic straps_valid_o
);

    // ****************************************
    // strap capture
    // ****************************************
    hsp_strap_if st ();

    hsp_strap_latch u_latch (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .ce_i(ce_i),
        .bus_role_strap_i(bus_role_strap_i),
        .power_ctl_polarity_strap_i(power_ctl_polarity_strap_i),
        .gang_strap_i(slave_addr_bit2_strap_i),
        .power_switching_disable_strap_i(power_switching_disable_strap_i),
        .test_i(test_i),
        .st(st)
    );

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [3:0] stat;
        logic [1:0] pwr;
        logic [1:0] port_oc;
        logic hub_oc;
        logic [2:0] addr;
    } hsp_top_t;

    hsp_top_t s_q;
    hsp_top_t s_d;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic drive_level(input logic on, input logic active_low);
        drive_level = on ^ active_low;
    endfunction : drive_level

    // power request after grouping and switching enable
    function automatic logic [1:0] power_plan(
        input logic [1:0] req,
        input logic gang,
        input logic dis
    );
        if (dis)
        begin
            power_plan = 2'h0;
        end
        else if (gang)
        begin
            power_plan = {2{|req}};
        end
        else
        begin
            power_plan = req;
        end
    endfunction : power_plan

    // overcurrent to hub or ports, {hub, port2, port1}
    function automatic logic [2:0] oc_plan(
        input logic [1:0] oc,
        input logic gang,
        input logic dis
    );
        if (dis)
        begin
            oc_plan = 3'h0;
        end
        else if (gang)
        begin
            oc_plan = {|oc, 2'h0};
        end
        else
        begin
            oc_plan = {1'h0, oc};
        end
    endfunction : oc_plan

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        logic [1:0] oc;
        oc = {~port2_overcurrent_n_i, ~port1_overcurrent_n_i};
        s_d = s_q;
        if (st.run)
        begin
            s_d.stat[0] = dn2_ss_conn_i;
            s_d.stat[1] = dn1_ss_conn_i;
            s_d.stat[2] = up_hs_conn_i;
            s_d.stat[3] = up_ss_conn_i;
            // address from strap pins, bit 3 fixed
            s_d.addr = {hsp_pkg::SLAVE_ADDR_BIT3, st.gang, st.pwr_dis};
            // power and overcurrent by grouping
            s_d.pwr = power_plan(port_power_req_i, st.gang, st.pwr_dis);
            {s_d.hub_oc, s_d.port_oc} = oc_plan(oc, st.gang, st.pwr_dis);
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            s_q.stat <= hsp_pkg::STATUS_RST;
            s_q.pwr <= hsp_pkg::POWER_REQ_RST;
            s_q.port_oc <= hsp_pkg::PORT_OC_RST;
            s_q.hub_oc <= hsp_pkg::HUB_OC_RST;
            s_q.addr <= hsp_pkg::SLAVE_ADDR_RST;
        end
        else if (ce_i)
        begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign dn2_superspeed_status_o = s_q.stat[0];
    assign dn1_superspeed_status_o = s_q.stat[1];
    assign upstream_highspeed_status_o = s_q.stat[2];
    assign upstream_superspeed_status_o = s_q.stat[3];

    // ****************************************
    // pin output enables
    // ****************************************
    assign dn2_superspeed_status_oe_o = st.run;
    assign dn1_superspeed_status_oe_o = st.run;
    assign upstream_highspeed_status_oe_o = st.run;
    assign upstream_superspeed_status_oe_o = st.run;

    // ****************************************
    // power and overcurrent
    // ****************************************
    assign port_power_control_o[0] = drive_level(s_q.pwr[0], st.pol);
    assign port_power_control_o[1] = drive_level(s_q.pwr[1], st.pol);
    assign port_overcurrent_o = s_q.port_oc;
    assign hub_overcurrent_o = s_q.hub_oc;

    // ****************************************
    // serial steering
    // ****************************************
    assign eeprom_master_sel_o = st.run & st.bus_role;
    assign smbus_slave_sel_o = st.run & ~st.bus_role;
    assign smbus_slave_addr_o = s_q.addr;

    // ****************************************
    // configuration
    // ****************************************
    assign gang_mode_o = st.gang;
    assign power_switching_en_o = ~st.pwr_dis;
    assign factory_test_o = st.test;
    assign straps_valid_o = st.run;

endmodule : hsp_strap_top

/* File: hsp_strap_top_sva.sv */
`timescale 1ns/100ps
module hsp_strap_top_sva (
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    // watched pins
    input wire logic dn2_ss_conn_i,
    input wire logic up_ss_conn_i,
    input wire logic [1:0] port_power_req_i,
    input wire logic port1_overcurrent_n_i,
    input wire logic port2_overcurrent_n_i,
    input wire logic power_ctl_polarity_strap_i,
    input wire logic dn2_superspeed_status_o,
    input wire logic dn2_superspeed_status_oe_o,
    input wire logic upstream_superspeed_status_o,
    input wire logic [1:0] port_power_control_o,
    input wire logic [1:0] port_overcurrent_o,
    input wire logic hub_overcurrent_o,
    input wire logic eeprom_master_sel_o,
    input wire logic smbus_slave_sel_o,
    input wire logic [2:0] smbus_slave_addr_o,
    input wire logic gang_mode_o,
    input wire logic power_switching_en_o,
    input wire logic factory_test_o,
    input wire logic straps_valid_o
);
    // ****
    // checks
    // ****
    logic upd_q;
    logic pol_q;
    logic [1:0] req_q;
    logic [1:0] oc;
    logic [1:0] pwr_exp;
    assign oc = ~{port2_overcurrent_n_i, port1_overcurrent_n_i};
    assign pwr_exp = {2{pol_q}} ^ (!power_switching_en_o ? 2'h0 :
        gang_mode_o ? {2{|req_q}} : req_q);
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            upd_q <= 1'h0;
            pol_q <= 1'h0;
            req_q <= 2'h0;
        end
        else
        begin
            upd_q <= straps_valid_o & ce_i;
            req_q <= port_power_req_i;
            if (!straps_valid_o && ce_i)
                pol_q <= power_ctl_polarity_strap_i;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    chk_oe_valid: assert property (dn2_superspeed_status_oe_o == straps_valid_o)
        else $error("oe wrong");
    chk_role_sel: assert property (straps_valid_o |-> eeprom_master_sel_o ^ smbus_slave_sel_o)
        else $error("sel wrong");
    chk_dn2_stat: assert property (upd_q |-> dn2_superspeed_status_o == $past(dn2_ss_conn_i))
        else $error("dn2 wrong");
    chk_up_ss: assert property (upd_q |-> upstream_superspeed_status_o == $past(up_ss_conn_i))
        else $error("up wrong");
    chk_strap_hold: assert property (straps_valid_o && $past(straps_valid_o) |->
        $stable({gang_mode_o, power_switching_en_o, factory_test_o, eeprom_master_sel_o}))
        else $error("strap moved");
    chk_addr_bits: assert property (upd_q |->
        smbus_slave_addr_o == {1'h1, gang_mode_o, !power_switching_en_o})
        else $error("addr wrong");
    chk_pwr_pol: assert property (upd_q |-> port_power_control_o == pwr_exp)
        else $error("pwr wrong");
    chk_gang_oc: assert property (upd_q && gang_mode_o && power_switching_en_o |->
        hub_overcurrent_o == |$past(oc) && port_overcurrent_o == 2'h0)
        else $error("gang oc wrong");
    chk_port_oc: assert property (upd_q && !gang_mode_o && power_switching_en_o |->
        port_overcurrent_o == $past(oc) && !hub_overcurrent_o)
        else $error("port oc wrong");
    cover property (straps_valid_o && smbus_slave_sel_o);
    cover property (hub_overcurrent_o);
    cover property (|port_overcurrent_o);
endmodule : hsp_strap_top_sva

bind hsp_strap_top hsp_strap_top_sva chk_u (.*);

/* File: hsp_board.sv */
`timescale 1ns/100ps
module hsp_board (
    // straps and hub drive
    input wire logic [3:0] strap_i,
    input wire logic [3:0] out_i,
    input wire logic [3:0] oe_i,
    // pin levels
    output logic [3:0] pin_o
);
    // ****
    // pull level unless hub drives
    // ****
    assign pin_o = (oe_i & out_i) | (~oe_i & strap_i);
endmodule : hsp_board

/* File: hsp_strap_top_tb.sv */
`timescale 1ns/100ps
module hsp_strap_top_tb;
    // ****
    // bench
    // ****
    logic mclk_i, arst_n_i, ce_i, test_i, dn1_ss_conn_i, dn2_ss_conn_i, up_hs_conn_i;
    logic up_ss_conn_i, port1_overcurrent_n_i, port2_overcurrent_n_i, hub_overcurrent_o;
    logic [1:0] port_power_req_i, port_power_control_o, port_overcurrent_o;
    logic bus_role_strap_i, power_ctl_polarity_strap_i, slave_addr_bit2_strap_i;
    logic power_switching_disable_strap_i, eeprom_master_sel_o, smbus_slave_sel_o;
    logic dn2_superspeed_status_o, dn1_superspeed_status_o, upstream_highspeed_status_o;
    logic upstream_superspeed_status_o, dn2_superspeed_status_oe_o, dn1_superspeed_status_oe_o;
    logic upstream_highspeed_status_oe_o, upstream_superspeed_status_oe_o, gang_mode_o;
    logic power_switching_en_o, factory_test_o, straps_valid_o, tst;
    logic [2:0] smbus_slave_addr_o;
    logic [3:0] st, cn;
    logic [4:0] r;
    int miscompares, total_checks;
    hsp_strap_top dut_u (.*);
    hsp_board brd_u (.strap_i(st), .out_i({dn2_superspeed_status_o, dn1_superspeed_status_o,
        upstream_highspeed_status_o, upstream_superspeed_status_o}),
        .oe_i({dn2_superspeed_status_oe_o, dn1_superspeed_status_oe_o,
        upstream_highspeed_status_oe_o, upstream_superspeed_status_oe_o}),
        .pin_o({bus_role_strap_i, power_ctl_polarity_strap_i, slave_addr_bit2_strap_i,
        power_switching_disable_strap_i}));
    initial
    begin
        mclk_i = 1'h0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    function automatic logic [3:0] exp_pwr(logic [1:0] q, logic [3:0] s);
        logic [1:0] g;
        g = s[1] ? {2{|q}} : q;
        return {2'h0, (g & {2{!s[0]}}) ^ {2{s[2]}}};
    endfunction : exp_pwr
    function automatic logic [3:0] exp_oc(logic [3:0] s, logic [1:0] o);
        return s[0] ? 4'h0 : s[1] ? {1'h0, !(&o), 2'h0} : {2'h0, ~o};
    endfunction : exp_oc
    task automatic chk(input logic [3:0] g, input logic [3:0] e);
        total_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task report_and_stop;
        if (miscompares == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    initial
    begin
        {arst_n_i, test_i, st, cn, port_power_req_i} = '0;
        {ce_i, port1_overcurrent_n_i, port2_overcurrent_n_i} = 3'h7;
        {dn2_ss_conn_i, dn1_ss_conn_i, up_hs_conn_i, up_ss_conn_i} = 4'h0;
        void'($urandom(61));
        for (int t = 0; t < 12; t++)
        begin
            r = (t == 0) ? 5'h00 : (t == 1) ? 5'h1F : 5'($urandom);
            @(negedge mclk_i);
            arst_n_i = 1'h0;
            {st, tst} = r;
            test_i = tst;
            repeat (2) @(negedge mclk_i);
            arst_n_i = 1'h1;
            repeat (2) @(negedge mclk_i);
            chk({1'h0, straps_valid_o, eeprom_master_sel_o, smbus_slave_sel_o}, {2'h1, st[3], !st[3]});
            chk({1'h0, gang_mode_o, power_switching_en_o, factory_test_o}, {1'h0, st[1], !st[0], tst});
            chk({1'h0, smbus_slave_addr_o}, {2'h1, st[1], st[0]});
            test_i = 1'h0;
            repeat (20)
            begin
                {cn, port_power_req_i, port1_overcurrent_n_i, port2_overcurrent_n_i} = 8'($urandom);
                {dn2_ss_conn_i, dn1_ss_conn_i, up_hs_conn_i, up_ss_conn_i} = cn;
                @(negedge mclk_i);
                chk({dn2_superspeed_status_o, dn1_superspeed_status_o, upstream_highspeed_status_o,
                    upstream_superspeed_status_o}, cn);
                chk({bus_role_strap_i, power_ctl_polarity_strap_i, slave_addr_bit2_strap_i,
                    power_switching_disable_strap_i}, cn);
                chk({2'h0, port_power_control_o}, exp_pwr(port_power_req_i, st));
                chk({1'h0, hub_overcurrent_o, port_overcurrent_o},
                    exp_oc(st, {port2_overcurrent_n_i, port1_overcurrent_n_i}));
                chk({gang_mode_o, power_switching_en_o, eeprom_master_sel_o, factory_test_o},
                    {st[1], !st[0], st[3], tst});
            end
            ce_i = 1'h0;
            {dn2_ss_conn_i, dn1_ss_conn_i, up_hs_conn_i, up_ss_conn_i} = ~cn;
            @(negedge mclk_i);
            chk({dn2_superspeed_status_o, dn1_superspeed_status_o, upstream_highspeed_status_o,
                upstream_superspeed_status_o}, cn);
            ce_i = 1'h1;
        end
        report_and_stop;
    end
endmodule : hsp_strap_top_tb
